// File: verilog/scan_timer_counter_unit.sv
// Purpose: Bank of scan-evaluated timers and edge counters behind APB
// Assumes: Program-side inputs and scan_end are synchronous to pclk
// Notes:   One timebase step at most is applied per scan
//
// Operation
// - On-delay counts up per tick while input on
// - On-delay contact on at value equal preset
// - On-delay input off clears value, contact off
// - Off-delay input on: contact on, value preset
// - Off-delay input off: count down, off at zero
// - Off-delay input return reloads preset, stays on
// - Cumulative counts only while on, keeps value
// - Cumulative contact cleared only by reset
// - Monostable pulse ignores input until zero
// - Retrigger pulse loads preset, off at zero
// - Retrigger new rising input reloads preset
// - Timers update only at scan end
// - Counters step one per rising input edge
// - Up counter on at preset, reset clears
// - Down counter on at zero, reset clears
// - Up/down contact on when value >= preset
// - Up/down reset clears value
// - Ring counter wraps to zero after preset
// - Ring contact on only at preset
// - Ring reset forces value zero
// - Timebase 100 ms, 10 ms or 1 ms
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module scan_timer_counter_unit #(
  parameter int unsigned NUM_CH          = 4,
  parameter int unsigned TICK_1MS_CYCLES = scan_timer_pkg::TICK_1MS_CYCLES
) (
  // Clock and reset
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  // APB slave
  input  wire logic [7:0]                              paddr,
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [31:0]                             pwdata,
  input  wire logic [3:0]                              pstrb,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // Program side
  input  wire logic                                    scan_end,
  input  wire logic [NUM_CH-1:0]                       in_cond,
  input  wire logic [NUM_CH-1:0]                       dn_cond,
  input  wire logic [NUM_CH-1:0]                       rst_cond,
  output logic      [NUM_CH-1:0]                       contact,
  output logic      [NUM_CH-1:0][scan_timer_pkg::VALUE_W-1:0] cur_value
);

  localparam int unsigned DIV_W = $clog2(TICK_1MS_CYCLES);
  localparam int unsigned DEC_W = $clog2(scan_timer_pkg::TB_DEC_RATIO);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_1MS_CYCLES - 1);
  localparam logic [DEC_W-1:0] DEC_LAST = DEC_W'(scan_timer_pkg::TB_DEC_RATIO - 1);
  localparam logic [15:0]      VMAX     = 16'hFFFF;

  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
    $error("NUM_CH must be 1 to 16");
  end
  if (TICK_1MS_CYCLES < 2) begin : g_bad_div
    $error("TICK_1MS_CYCLES must be at least 2");
  end

  // Timebase dividers: 1 ms from pclk, then two decades
  logic [DIV_W-1:0] div_1ms;
  logic [DEC_W-1:0] div_10ms;
  logic [DEC_W-1:0] div_100ms;
  logic [2:0]       pend;
  logic [DIV_W-1:0] next_div_1ms;
  logic [DEC_W-1:0] next_div_10ms;
  logic [DEC_W-1:0] next_div_100ms;
  logic [2:0]       next_pend;
  logic [2:0]       ticks;

  always_comb begin
    ticks[2]       = (div_1ms == DIV_LAST);
    ticks[1]       = ticks[2] && (div_10ms == DEC_LAST);
    ticks[0]       = ticks[1] && (div_100ms == DEC_LAST);
    next_div_1ms   = ticks[2] ? '0 : div_1ms + 1'b1;
    next_div_10ms  = div_10ms;
    next_div_100ms = div_100ms;
    if (ticks[2]) begin
      next_div_10ms = ticks[1] ? '0 : div_10ms + 1'b1;
    end
    if (ticks[1]) begin
      next_div_100ms = ticks[0] ? '0 : div_100ms + 1'b1;
    end
    // A tick landing on scan end stays pending for the next scan
    next_pend = (pend & ~{3{scan_end}}) | ticks;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_1ms   <= '0;
      div_10ms  <= '0;
      div_100ms <= '0;
      pend      <= 3'h0;
    end else begin
      div_1ms   <= next_div_1ms;
      div_10ms  <= next_div_10ms;
      div_100ms <= next_div_100ms;
      pend      <= next_pend;
    end
  end

  // APB register file
  scan_timer_pkg::chan_cfg_t [NUM_CH-1:0] cfg;
  scan_timer_pkg::chan_cfg_t [NUM_CH-1:0] next_cfg;
  scan_timer_pkg::chan_state_t [NUM_CH-1:0] st;
  scan_timer_pkg::chan_state_t [NUM_CH-1:0] next_st;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [3:0]  sel_ch;
  logic [3:0]  sel_reg;
  logic        ch_ok;
  logic        addr_ok;
  logic        wr_take;

  always_comb begin
    sel_ch       = paddr[7:scan_timer_pkg::CH_STRIDE_LOG2];
    sel_reg      = paddr[3:0];
    ch_ok        = (32'(sel_ch) < NUM_CH);
    addr_ok      = ch_ok && (sel_reg == scan_timer_pkg::REG_CTRL ||
                   sel_reg == scan_timer_pkg::REG_PRESET ||
                   (sel_reg == scan_timer_pkg::REG_VALUE && !pwrite));
    // Answer one cycle after setup; write lands on the pready edge
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok;
    next_prdata  = 32'h0000_0000;
    wr_take      = psel && penable && pready && pwrite && !pslverr;
    next_cfg     = cfg;
    if (psel && !penable && !pwrite && addr_ok) begin
      case (sel_reg)
        scan_timer_pkg::REG_CTRL: begin
          next_prdata[scan_timer_pkg::MODE_LSB +: 4] = cfg[sel_ch].mode;
          next_prdata[scan_timer_pkg::TB_LSB +: 2]   = cfg[sel_ch].tb;
        end
        scan_timer_pkg::REG_PRESET: begin
          next_prdata[15:0] = cfg[sel_ch].preset;
        end
        default: begin
          next_prdata[15:0]                        = st[sel_ch].value;
          next_prdata[scan_timer_pkg::CONTACT_BIT] = st[sel_ch].contact;
          next_prdata[scan_timer_pkg::BUSY_BIT]    = st[sel_ch].busy;
        end
      endcase
    end
    if (wr_take) begin
      case (sel_reg)
        scan_timer_pkg::REG_CTRL: begin
          if (pstrb[0]) begin
            next_cfg[sel_ch].mode =
              scan_timer_pkg::mode_t'(pwdata[scan_timer_pkg::MODE_LSB +: 4]);
            next_cfg[sel_ch].tb =
              scan_timer_pkg::timebase_t'(pwdata[scan_timer_pkg::TB_LSB +: 2]);
          end
        end
        default: begin
          if (pstrb[0]) next_cfg[sel_ch].preset[7:0] = pwdata[7:0];
          if (pstrb[1]) next_cfg[sel_ch].preset[15:8] = pwdata[15:8];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg     <= {NUM_CH{scan_timer_pkg::CFG_RESET}};
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Channel evaluation, only on the scan-end pulse
  logic [NUM_CH-1:0] rise_in;
  logic [NUM_CH-1:0] rise_dn;
  logic [NUM_CH-1:0] fall_rst;
  logic [NUM_CH-1:0] step;

  always_comb begin
    next_st = st;
    for (int i = 0; i < NUM_CH; i++) begin
      rise_in[i]  = in_cond[i] && !st[i].prev_in;
      rise_dn[i]  = dn_cond[i] && !st[i].prev_dn;
      fall_rst[i] = !rst_cond[i] && st[i].prev_rst;
      step[i]     = (cfg[i].tb == scan_timer_pkg::tb_stop) ? 1'b0 : pend[cfg[i].tb];
      if (scan_end) begin
        next_st[i].prev_in  = in_cond[i];
        next_st[i].prev_dn  = dn_cond[i];
        next_st[i].prev_rst = rst_cond[i];
        if (rst_cond[i]) begin
          next_st[i].value   = '0;
          next_st[i].contact = 1'b0;
          next_st[i].busy    = 1'b0;
        end else begin
          case (cfg[i].mode)
            scan_timer_pkg::on_delay_timer: begin
              if (!in_cond[i]) begin
                next_st[i].value = '0;
              end else if (step[i] && st[i].value < cfg[i].preset) begin
                next_st[i].value = st[i].value + 1'b1;
              end
              next_st[i].contact = in_cond[i] && (next_st[i].value == cfg[i].preset);
            end
            scan_timer_pkg::off_delay_timer: begin
              if (in_cond[i]) begin
                next_st[i].value   = cfg[i].preset;
                next_st[i].contact = 1'b1;
              end else if (st[i].value != '0) begin
                if (step[i]) next_st[i].value = st[i].value - 1'b1;
                next_st[i].contact = (next_st[i].value != '0);
              end else begin
                next_st[i].contact = 1'b0;
              end
            end
            scan_timer_pkg::cumulative_timer: begin
              if (in_cond[i] && step[i] && st[i].value < cfg[i].preset) begin
                next_st[i].value = st[i].value + 1'b1;
              end
              next_st[i].contact = st[i].contact ||
                                   (next_st[i].value >= cfg[i].preset);
            end
            scan_timer_pkg::monostable_timer: begin
              if (!st[i].busy) begin
                if (rise_in[i]) begin
                  next_st[i].value   = cfg[i].preset;
                  next_st[i].busy    = (cfg[i].preset != '0);
                  next_st[i].contact = (cfg[i].preset != '0);
                end
              end else if (step[i]) begin
                next_st[i].value   = st[i].value - 1'b1;
                next_st[i].busy    = (st[i].value != 16'h0001);
                next_st[i].contact = (st[i].value != 16'h0001);
              end
            end
            scan_timer_pkg::retrigger_timer: begin
              if (rise_in[i]) begin
                next_st[i].value   = cfg[i].preset;
                next_st[i].busy    = (cfg[i].preset != '0);
                next_st[i].contact = (cfg[i].preset != '0);
              end else if (st[i].busy && step[i]) begin
                next_st[i].value   = st[i].value - 1'b1;
                next_st[i].busy    = (st[i].value != 16'h0001);
                next_st[i].contact = (st[i].value != 16'h0001);
              end
            end
            scan_timer_pkg::up_counter: begin
              if (rise_in[i] && st[i].value != VMAX) begin
                next_st[i].value = st[i].value + 1'b1;
              end
              next_st[i].contact = (next_st[i].value >= cfg[i].preset);
            end
            scan_timer_pkg::down_counter: begin
              // Reset release arms the count at the preset
              if (fall_rst[i]) begin
                next_st[i].value = cfg[i].preset;
              end else if (rise_in[i] && st[i].value != '0) begin
                next_st[i].value   = st[i].value - 1'b1;
                next_st[i].contact = (st[i].value == 16'h0001);
              end
            end
            scan_timer_pkg::up_down_counter: begin
              if (rise_in[i] && !rise_dn[i] && st[i].value != VMAX) begin
                next_st[i].value = st[i].value + 1'b1;
              end else if (rise_dn[i] && !rise_in[i] && st[i].value != '0) begin
                next_st[i].value = st[i].value - 1'b1;
              end
              next_st[i].contact = (next_st[i].value >= cfg[i].preset);
            end
            scan_timer_pkg::ring_counter: begin
              if (rise_in[i]) begin
                next_st[i].value = (st[i].value >= cfg[i].preset) ? '0 : st[i].value + 1'b1;
              end
              next_st[i].contact = (next_st[i].value == cfg[i].preset);
            end
            default: begin
              next_st[i].value   = '0;
              next_st[i].contact = 1'b0;
              next_st[i].busy    = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= {NUM_CH{scan_timer_pkg::STATE_RESET}};
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      contact[i]   = st[i].contact;
      cur_value[i] = st[i].value;
    end
  end

  // Checks on channel 0 and on the APB answer timing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_scan0;
    scan_end && !rst_cond[0];
  endsequence
  sequence s_rise0;
    s_scan0 ##0 (in_cond[0] && !st[0].prev_in);
  endsequence

  property p_scan_only;
    !scan_end |=> ($stable(st[0].value) && $stable(st[0].contact));
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("state moved off scan end");
  property p_on_delay_clear;
    s_scan0 ##0 (cfg[0].mode == scan_timer_pkg::on_delay_timer && !in_cond[0])
      |=> (st[0].value == 16'h0000 && !st[0].contact);
  endproperty
  a_on_delay_clear: assert property (p_on_delay_clear) else $error("on-delay not cleared");
  property p_on_delay_done;
    s_scan0 ##0 (cfg[0].mode == scan_timer_pkg::on_delay_timer && in_cond[0] &&
                 st[0].value == cfg[0].preset) |=> st[0].contact;
  endproperty
  a_on_delay_done: assert property (p_on_delay_done) else $error("on-delay contact off");
  property p_off_delay_hold;
    s_scan0 ##0 (cfg[0].mode == scan_timer_pkg::off_delay_timer && in_cond[0])
      |=> (st[0].contact && st[0].value == $past(cfg[0].preset));
  endproperty
  a_off_delay_hold: assert property (p_off_delay_hold) else $error("off-delay not loaded");
  property p_cumul_keep;
    s_scan0 ##0 (cfg[0].mode == scan_timer_pkg::cumulative_timer && st[0].contact)
      |=> st[0].contact;
  endproperty
  a_cumul_keep: assert property (p_cumul_keep) else $error("cumulative contact lost");
  property p_up_step;
    s_rise0 ##0 (cfg[0].mode == scan_timer_pkg::up_counter && st[0].value != VMAX)
      |=> st[0].value == $past(st[0].value) + 16'h0001;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up counter missed edge");
  property p_reset_clears;
    scan_end && rst_cond[0] |=> (st[0].value == 16'h0000 && !st[0].contact);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");
  property p_ring_wrap;
    s_rise0 ##0 (cfg[0].mode == scan_timer_pkg::ring_counter &&
                 st[0].value == cfg[0].preset) |=> st[0].value == 16'h0000;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) else $error("ring did not wrap");
  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
endmodule

// File: verilog/scan_timer_pkg.sv
// Purpose: Shared constants and types for the scan timer/counter bank
// Assumes: 40 MHz pclk, 32-bit APB, one 16-byte register window per channel
// Notes:   Register offsets are byte addresses within a channel window
package scan_timer_pkg;

  // Register map: channel window base is channel index times stride
  localparam int unsigned CH_STRIDE_LOG2 = 4;
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_PRESET     = 4'h4;
  localparam logic [3:0]  REG_VALUE      = 4'h8;

  // Field positions
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned TB_LSB      = 4;
  localparam int unsigned CONTACT_BIT = 16;
  localparam int unsigned BUSY_BIT    = 17;
  localparam int unsigned VALUE_W     = 16;

  // Timebase timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned TB_1MS_NS       = 1000000;
  localparam int unsigned TICK_1MS_CYCLES = TB_1MS_NS / CLK_PERIOD_NS;
  localparam int unsigned TB_DEC_RATIO    = 10;

  typedef enum logic [3:0] {
    on_delay_timer,
    off_delay_timer,
    cumulative_timer,
    monostable_timer,
    retrigger_timer,
    up_counter,
    down_counter,
    up_down_counter,
    ring_counter
  } mode_t;

  typedef enum logic [1:0] {
    tb_100ms,
    tb_10ms,
    tb_1ms,
    tb_stop
  } timebase_t;

  typedef struct packed {
    mode_t              mode;
    timebase_t          tb;
    logic [VALUE_W-1:0] preset;
  } chan_cfg_t;

  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic               contact;
    logic               prev_in;
    logic               prev_dn;
    logic               prev_rst;
    logic               busy;
  } chan_state_t;

  // Reset values
  localparam chan_cfg_t   CFG_RESET   = '{mode: on_delay_timer, tb: tb_100ms, preset: 16'h0000};
  localparam chan_state_t STATE_RESET = '{value: 16'h0000, contact: 1'b0, prev_in: 1'b0,
                                          prev_dn: 1'b0, prev_rst: 1'b0, busy: 1'b0};

endpackage

// File: tb/scan_program_model.sv
// Purpose: Program-side model that paces scan ends and presents levels
// Assumes: Same clock as the unit; the bench requests the levels
// Notes:   Levels change only mid-scan, so each stands a whole scan
`timescale 1ns/1ps
module scan_program_model #(
  parameter int NUM_CH = 4,
  parameter int SCAN   = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Requested levels
  input  wire logic [NUM_CH-1:0] req_in,
  input  wire logic [NUM_CH-1:0] req_dn,
  input  wire logic [NUM_CH-1:0] req_rst,
  // Program side of the unit
  output logic                   scan_end,
  output logic      [NUM_CH-1:0] in_cond,
  output logic      [NUM_CH-1:0] dn_cond,
  output logic      [NUM_CH-1:0] rst_cond
);
  int cnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 0;
      scan_end <= 1'b0;
      in_cond  <= '0;
      dn_cond  <= '0;
      rst_cond <= '0;
    end else begin
      cnt      <= (cnt == SCAN - 1) ? 0 : cnt + 1;
      scan_end <= (cnt == SCAN - 2);
      // Mid-scan update holds every level for exactly one whole scan
      if (cnt == SCAN / 2) begin
        in_cond  <= req_in;
        dn_cond  <= req_dn;
        rst_cond <= req_rst;
      end
    end
  end
endmodule

// File: tb/scan_timer_counter_unit_tb.sv
// Purpose: Self-checking bench for the scan timer/counter unit
// Assumes: Model paces scans every 8 cycles; channel 0 runs the mode table
// Notes:   Tick of 2 cycles makes the 1 ms base step once per scan
`timescale 1ns/1ps
module scan_timer_counter_unit_tb;
  localparam int NCH = 4;

  typedef struct packed {
    logic [3:0]  m;
    logic [15:0] p;
    logic        i;
    logic        d;
    logic        r;
    logic [3:0]  n;
    logic [15:0] v;
    logic        c;
    logic        cv;
  } row_t;

  // Mode, preset, in, dn, rst, scans, value, contact, value checked
  row_t rows [54] = '{
    '{0,3,0,0,1,1,0,0,1}, '{0,3,1,0,0,2,2,0,1}, '{0,3,1,0,0,3,3,1,1},
    '{0,3,0,0,0,1,0,0,1}, '{1,3,1,0,0,1,3,1,1}, '{1,3,0,0,0,2,1,1,1},
    '{1,3,1,0,0,1,3,1,1}, '{1,3,0,0,0,3,0,0,1}, '{2,4,0,0,1,1,0,0,1},
    '{2,4,1,0,0,2,2,0,1}, '{2,4,0,0,0,2,2,0,1}, '{2,4,1,0,0,3,4,1,1},
    '{2,4,0,0,0,2,4,1,1}, '{2,4,0,0,1,1,0,0,1}, '{3,4,1,0,0,1,0,1,0},
    '{3,4,0,0,0,1,0,1,0}, '{3,4,1,0,0,1,0,1,0}, '{3,4,0,0,0,2,0,0,1},
    '{4,4,1,0,0,1,0,1,0}, '{4,4,0,0,0,1,0,1,0}, '{4,4,1,0,0,1,0,1,0},
    '{4,4,0,0,0,2,0,1,0}, '{4,4,0,0,0,3,0,0,1}, '{5,3,1,0,0,1,1,0,1},
    '{5,3,1,0,0,2,1,0,1}, '{5,3,0,0,0,1,1,0,1}, '{5,3,1,0,0,1,2,0,1},
    '{5,3,0,0,0,1,2,0,1}, '{5,3,1,0,0,1,3,1,1}, '{5,3,1,0,1,1,0,0,1},
    '{5,3,0,0,1,1,0,0,1}, '{5,3,1,0,1,1,0,0,1}, '{6,3,0,0,1,1,0,0,1},
    '{6,3,0,0,0,1,3,0,1}, '{6,3,1,0,0,1,2,0,1}, '{6,3,0,0,0,1,2,0,1},
    '{6,3,1,0,0,1,1,0,1}, '{6,3,0,0,0,1,1,0,1}, '{6,3,1,0,0,1,0,1,1},
    '{6,3,0,0,0,1,0,1,1}, '{7,2,0,0,1,1,0,0,1}, '{7,2,1,0,0,1,1,0,1},
    '{7,2,0,0,0,1,1,0,1}, '{7,2,1,0,0,1,2,1,1}, '{7,2,0,1,0,1,1,0,1},
    '{7,2,0,0,1,1,0,0,1}, '{8,2,1,0,0,1,1,0,1}, '{8,2,0,0,0,1,1,0,1},
    '{8,2,1,0,0,1,2,1,1}, '{8,2,0,0,0,1,2,1,1}, '{8,2,1,0,0,1,0,0,1},
    '{8,2,0,0,0,1,0,0,1}, '{8,2,1,0,0,1,1,0,1}, '{8,2,0,0,1,1,0,0,1}
  };

  logic                  pclk    = 1'b0;
  logic                  presetn = 1'b0;
  logic [7:0]            paddr   = 8'h00;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [31:0]           pwdata  = 32'h0;
  logic [3:0]            pstrb   = 4'hF;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  scan_end;
  logic [NCH-1:0]        in_cond;
  logic [NCH-1:0]        dn_cond;
  logic [NCH-1:0]        rst_cond;
  logic [NCH-1:0]        req_in  = '0;
  logic [NCH-1:0]        req_dn  = '0;
  logic [NCH-1:0]        req_rst = '0;
  logic [NCH-1:0]        contact;
  logic [NCH-1:0][15:0]  cur_value;
  logic [NCH-1:0]        con_q;
  logic [2:0]            se_q;
  logic [2:0]            bus_q;
  int                    err_total  = 0;
  int                    num_checks = 0;
  int                    cyc        = 0;

  always #12.5 pclk = ~pclk;

  scan_timer_counter_unit #(.NUM_CH(NCH), .TICK_1MS_CYCLES(2)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_end(scan_end), .in_cond(in_cond),
    .dn_cond(dn_cond), .rst_cond(rst_cond), .contact(contact), .cur_value(cur_value)
  );

  scan_program_model #(.NUM_CH(NCH), .SCAN(8)) model_u (
    .pclk(pclk), .presetn(presetn), .req_in(req_in), .req_dn(req_dn),
    .req_rst(req_rst), .scan_end(scan_end), .in_cond(in_cond),
    .dn_cond(dn_cond), .rst_cond(rst_cond)
  );

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic ee, output logic [31:0] r);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    check({31'h0, pslverr}, {31'h0, ee});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Leaves the bench early in a scan so new levels land before its end
  task automatic sync();
    @(posedge pclk iff scan_end === 1'b1);
    @(posedge pclk);
  endtask

  task automatic scans(input logic [3:0] n);
    repeat (n) @(posedge pclk iff scan_end === 1'b1);
    repeat (2) @(posedge pclk);
  endtask

  // Contacts may only move on the edge after a scan end
  always @(posedge pclk) begin
    se_q  <= {se_q[1:0], scan_end};
    bus_q <= {bus_q[1:0], psel | ~presetn};
    con_q <= contact;
    if (bus_q == 3'h0 && contact !== con_q && se_q[0] !== 1'b1)
      check({28'h0, contact}, {28'h0, con_q});
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] rd;
    logic [3:0]  last_m;
    last_m = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[k]) begin
      if (rows[k].m !== last_m) begin
        apb(8'h00, 1'b1, {26'h0, 2'h2, rows[k].m}, 1'b0, rd);
        apb(8'h04, 1'b1, {16'h0, rows[k].p}, 1'b0, rd);
        last_m = rows[k].m;
        sync();
      end
      req_in  <= {3'h0, rows[k].i};
      req_dn  <= {3'h0, rows[k].d};
      req_rst <= {3'h0, rows[k].r};
      scans(rows[k].n);
      if (rows[k].cv === 1'b1) check({16'h0, cur_value[0]}, {16'h0, rows[k].v});
      check({31'h0, contact[0]}, {31'h0, rows[k].c});
    end
    // Channel 1 on the 10 ms base cannot reach preset 2 in two scans
    apb(8'h10, 1'b1, {26'h0, 2'h1, 4'h0}, 1'b0, rd);
    apb(8'h14, 1'b1, 32'h0000_0002, 1'b0, rd);
    sync();
    req_in <= 4'h2;
    scans(4'h2);
    check({31'h0, contact[1]}, 32'h0);
    scans(4'hA);
    check({16'h0, cur_value[1]}, 32'h0000_0002);
    apb(8'h18, 1'b0, 32'h0, 1'b0, rd);
    check(rd & 32'h0001_FFFF, 32'h0001_0002);
    // Stopped base freezes channel 2 although its input is on
    apb(8'h20, 1'b1, {26'h0, 2'h3, 4'h0}, 1'b0, rd);
    apb(8'h24, 1'b1, 32'h0000_0001, 1'b0, rd);
    req_in <= 4'h6;
    scans(4'h3);
    check({16'h0, cur_value[2]}, 32'h0);
    check({31'h0, contact[2]}, 32'h0);
    // Byte strobe limits a preset write to its low lane
    pstrb <= 4'h1;
    apb(8'h24, 1'b1, 32'h0000_FF05, 1'b0, rd);
    pstrb <= 4'hF;
    apb(8'h24, 1'b0, 32'h0, 1'b0, rd);
    check(rd, 32'h0000_0005);
    // Refused accesses leave state alone
    apb(8'h08, 1'b1, 32'h0000_FFFF, 1'b1, rd);
    apb(8'h40, 1'b0, 32'h0, 1'b1, rd);
    check(rd, 32'h0);
    apb(8'h0C, 1'b0, 32'h0, 1'b1, rd);
    apb(8'h08, 1'b0, 32'h0, 1'b0, rd);
    check(rd & 32'h0000_FFFF, 32'h0);
    apb(8'h00, 1'b0, 32'h0, 1'b0, rd);
    check(rd & 32'h0000_003F, 32'h0000_0028);
    // Second reset in mid-run
    req_in  <= 4'h0;
    presetn <= 1'b0;
    @(posedge pclk);
    check({28'h0, contact}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(8'h14, 1'b0, 32'h0, 1'b0, rd);
    check(rd, 32'h0);
    report_and_stop();
  end
endmodule
